// file: src/cidt_pkg.sv
// Purpose: Shared constants and types for the instruction decode and timing block
// Assumes: 24-bit instruction words, 8-bit opcode field in bits 23:16
// Notes: Opcode class boundaries are a compact model of the class map
package cidt_pkg;
   // ----------------------------------------
   // Word geometry
   // ----------------------------------------
   localparam int CIDT_IW = 24;
   localparam int CIDT_OPW = 8;
   localparam int CIDT_OP_LSB = 16;
   localparam int CIDT_REGW = 4;
   localparam int CIDT_FW = 13;
   localparam int CIDT_LITW = 16;
   localparam int CIDT_PAW = 23;
   localparam int CIDT_CYCW = 2;
   // Second word of a two-word instruction has a zero opcode
   localparam logic [7:0] CIDT_OP_NOP = 8'h00;
   // Two-word opcodes (three of them)
   localparam logic [7:0] CIDT_OP_GOTO2 = 8'h04;
   localparam logic [7:0] CIDT_OP_CALL2 = 8'h02;
   localparam logic [7:0] CIDT_OP_DOLOOP = 8'h08;
   // Multi-cycle single-word opcodes
   localparam logic [7:0] CIDT_OP_RELJMP = 8'h37;
   localparam logic [7:0] CIDT_OP_RELJMP_CMP = 8'h01;
   localparam logic [7:0] CIDT_OP_IND_CALL = 8'h0C;
   localparam logic [7:0] CIDT_OP_IND_GOTO = 8'h0D;
   localparam logic [7:0] CIDT_OP_SUB_RET = 8'h06;
   localparam logic [7:0] CIDT_OP_INT_RET = 8'h07;
   localparam logic [7:0] CIDT_OP_DBL_MOVE = 8'hBE;
   localparam logic [7:0] CIDT_OP_TBL_LO = 8'hBA;
   localparam logic [7:0] CIDT_OP_TBL_HI = 8'hBB;
   // Conditional branch range and skip range
   localparam logic [7:0] CIDT_OP_CBR_LO = 8'h30;
   localparam logic [7:0] CIDT_OP_CBR_HI = 8'h36;
   localparam logic [7:0] CIDT_OP_SKIP_LO = 8'hA6;
   localparam logic [7:0] CIDT_OP_SKIP_HI = 8'hA7;
   // Class boundaries on the opcode
   localparam logic [7:0] CIDT_OP_LITMOV_LO = 8'h20;
   localparam logic [7:0] CIDT_OP_LITMOV_HI = 8'h2F;
   localparam logic [7:0] CIDT_OP_DEFAULT_WORKING_REG_LO = 8'h40;
   localparam logic [7:0] CIDT_OP_DEFAULT_WORKING_REG_HI = 8'h77;
   localparam logic [7:0] CIDT_OP_BIT_LO = 8'hA0;
   localparam logic [7:0] CIDT_OP_BIT_HI = 8'hAF;
   localparam logic [7:0] CIDT_OP_LITALU_LO = 8'hB0;
   localparam logic [7:0] CIDT_OP_LITALU_HI = 8'hB3;
   localparam logic [7:0] CIDT_OP_FILE_LO = 8'hB4;
   localparam logic [7:0] CIDT_OP_FILE_HI = 8'hB9;
   // Cycle counts
   localparam logic [1:0] CIDT_CYC1 = 2'h1;
   localparam logic [1:0] CIDT_CYC2 = 2'h2;
   localparam logic [1:0] CIDT_CYC3 = 2'h3;
   // Field positions inside the word
   localparam int CIDT_BASE_LSB = 15;
   localparam int CIDT_DEST_LSB = 7;
   localparam int CIDT_DMOD_LSB = 11;
   localparam int CIDT_SMOD_LSB = 4;
   localparam int CIDT_SRC_LSB = 0;
   localparam int CIDT_FSEL_BIT = 13;
   localparam int CIDT_BIT_LSB = 12;
   localparam int CIDT_BITIND_BIT = 11;
   localparam int CIDT_TBLMODE_LSB = 14;
   localparam int CIDT_LIT_LSB = 4;
   localparam int CIDT_ALULIT_LSB = 4;

   typedef enum logic [2:0] {
      CIDT_CLS_CTRL = 3'h0,
      CIDT_CLS_DEFAULT_WORKING_REG = 3'h1,
      CIDT_CLS_FILE = 3'h2,
      CIDT_CLS_BIT = 3'h3,
      CIDT_CLS_LITMOV = 3'h4,
      CIDT_CLS_LITALU = 3'h5
   } cidt_class_e;
endpackage

// file: src/cidt_timing.sv
// Purpose: Cycle count for one decoded instruction
// Assumes: Opcode and condition inputs are valid in the same cycle
// Notes: Purely combinational
`timescale 1ns/1ps
module cidt_timing (
   input wire logic [7:0] i_opcode,
   input wire logic i_cond_true,
   input wire logic i_next_two_word,
   output logic o_two_word,
   output logic o_skip_op,
   output logic [1:0] o_cycles
);
   import cidt_pkg::*;

   // ----------------------------------------
   // Opcode tests
   // ----------------------------------------
   function automatic logic in_rng(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
      in_rng = (op >= lo) && (op <= hi);
   endfunction

   logic is_multi;
   logic is_cond;

   // Classify timing kinds
   always_comb begin
      o_two_word = (i_opcode == CIDT_OP_GOTO2) || (i_opcode == CIDT_OP_CALL2)
                   || (i_opcode == CIDT_OP_DOLOOP);
      o_skip_op = in_rng(i_opcode, CIDT_OP_SKIP_LO, CIDT_OP_SKIP_HI);
      is_cond = in_rng(i_opcode, CIDT_OP_CBR_LO, CIDT_OP_CBR_HI);
      is_multi = (i_opcode == CIDT_OP_RELJMP) || (i_opcode == CIDT_OP_RELJMP_CMP)
                 || (i_opcode == CIDT_OP_IND_CALL) || (i_opcode == CIDT_OP_IND_GOTO)
                 || (i_opcode == CIDT_OP_TBL_LO) || (i_opcode == CIDT_OP_TBL_HI)
                 || (i_opcode == CIDT_OP_SUB_RET) || (i_opcode == CIDT_OP_INT_RET);
   end

   // Cycle count selection
   always_comb begin
      o_cycles = CIDT_CYC1;
      if (o_two_word) begin
         o_cycles = CIDT_CYC2;
      end else if (i_opcode == CIDT_OP_DBL_MOVE) begin
         o_cycles = CIDT_CYC2;
      end else if (i_opcode == CIDT_OP_SUB_RET || i_opcode == CIDT_OP_INT_RET) begin
         o_cycles = CIDT_CYC3;
      end else if (is_multi) begin
         o_cycles = CIDT_CYC2;
      end else if (o_skip_op && i_cond_true) begin
         o_cycles = i_next_two_word ? CIDT_CYC3 : CIDT_CYC2;
      end else if (is_cond && i_cond_true) begin
         o_cycles = CIDT_CYC2;
      end
   end
endmodule

// file: src/cidt_decoder.sv
// Purpose: Instruction decode and cycle timing for fetched 24-bit words
// Assumes: One fetched word per cycle when i_valid, condition result supplied by datapath
// Notes: Holds o_cycles minus one wait cycles unless two-word, set by opcode, condition and next word; second words raise o_second_word, not o_nop_cycle
`timescale 1ns/1ps
module cidt_decoder (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [cidt_pkg::CIDT_IW-1:0] i_instr,
   input wire logic i_cond_true,
   input wire logic i_next_two_word,
   output logic o_ready,
   output logic o_dec_valid,
   output cidt_pkg::cidt_class_e o_class,
   output logic [cidt_pkg::CIDT_OPW-1:0] o_opcode,
   output logic [cidt_pkg::CIDT_REGW-1:0] o_base_source_reg,
   output logic [cidt_pkg::CIDT_REGW-1:0] o_second_source_reg,
   output logic [2:0] o_src_mod,
   output logic [cidt_pkg::CIDT_REGW-1:0] o_destination_reg,
   output logic [2:0] o_dst_mod,
   output logic o_dst_valid,
   output logic [cidt_pkg::CIDT_FW-1:0] o_file_addr,
   output logic o_to_file,
   output logic [3:0] o_bit_pos,
   output logic o_bit_indirect,
   output logic [cidt_pkg::CIDT_LITW-1:0] o_literal,
   output logic [cidt_pkg::CIDT_PAW-1:0] o_prog_addr,
   output logic [1:0] o_tbl_mode,
   output logic o_two_word,
   output logic o_second_word,
   output logic [1:0] o_cycles,
   output logic o_nop_cycle
);
   import cidt_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic in_rng(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
      in_rng = (op >= lo) && (op <= hi);
   endfunction

   // Opcode to operand class
   function automatic cidt_class_e op_class(input logic [7:0] op);
      if (in_rng(op, CIDT_OP_DEFAULT_WORKING_REG_LO, CIDT_OP_DEFAULT_WORKING_REG_HI)) op_class = CIDT_CLS_DEFAULT_WORKING_REG;
      else if (in_rng(op, CIDT_OP_FILE_LO, CIDT_OP_FILE_HI)) op_class = CIDT_CLS_FILE;
      else if (in_rng(op, CIDT_OP_BIT_LO, CIDT_OP_BIT_HI)) op_class = CIDT_CLS_BIT;
      else if (in_rng(op, CIDT_OP_LITMOV_LO, CIDT_OP_LITMOV_HI)) op_class = CIDT_CLS_LITMOV;
      else if (in_rng(op, CIDT_OP_LITALU_LO, CIDT_OP_LITALU_HI)) op_class = CIDT_CLS_LITALU;
      else op_class = CIDT_CLS_CTRL;
   endfunction

   typedef enum logic [1:0] {
      CIDT_ST_IDLE = 2'b00,
      CIDT_ST_WAIT = 2'b01,
      CIDT_ST_WORD2 = 2'b11
   } cidt_state_e;

   // ----------------------------------------
   // Timing sub-block
   // ----------------------------------------
   logic [7:0] op;
   logic tw;
   logic skip_op;
   logic [1:0] cyc;

   assign op = i_instr[CIDT_OP_LSB +: CIDT_OPW];

   cidt_timing u_timing (
      .i_opcode(op),
      .i_cond_true(i_cond_true),
      .i_next_two_word(i_next_two_word),
      .o_two_word(tw),
      .o_skip_op(skip_op),
      .o_cycles(cyc)
   );

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   cidt_state_e state_r, state_nxt;
   logic [1:0] left_r, left_nxt;
   logic [CIDT_PAW-1:0] addr_hi_r, addr_hi_nxt;
   logic take;

   // Word accepted only when no cycles are owed
   assign o_ready = (state_r == CIDT_ST_IDLE) || (state_r == CIDT_ST_WORD2);
   assign take = i_valid && o_ready;

   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      left_nxt = left_r;
      addr_hi_nxt = addr_hi_r;
      unique case (state_r)
         CIDT_ST_IDLE: begin
            if (take) begin
               if (tw) begin
                  state_nxt = CIDT_ST_WORD2;
                  addr_hi_nxt = {{(CIDT_PAW-16){1'b0}}, i_instr[15:0]};
               end else if (cyc != CIDT_CYC1) begin
                  state_nxt = CIDT_ST_WAIT;
                  left_nxt = cyc - CIDT_CYC1;
               end
            end
         end
         CIDT_ST_WAIT: begin
            left_nxt = left_r - 2'h1;
            if (left_r == 2'h1) begin
               state_nxt = CIDT_ST_IDLE;
            end
         end
         CIDT_ST_WORD2: begin
            if (take) begin
               state_nxt = CIDT_ST_IDLE;
            end
         end
         default: begin
            state_nxt = CIDT_ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= CIDT_ST_IDLE;
         left_r <= 2'h0;
         addr_hi_r <= '0;
      end else begin
         state_r <= state_nxt;
         left_r <= left_nxt;
         addr_hi_r <= addr_hi_nxt;
      end
   end

   // ----------------------------------------
   // Operand extraction
   // ----------------------------------------
   logic dv_nxt, tw_nxt, w2_nxt, tof_nxt, bind_nxt, dval_nxt, nop_nxt;
   cidt_class_e cls_nxt;
   logic [7:0] opc_nxt;
   logic [3:0] base_nxt, src_nxt, dst_nxt, bit_nxt;
   logic [2:0] smod_nxt, dmod_nxt;
   logic [CIDT_FW-1:0] f_nxt;
   logic [CIDT_LITW-1:0] lit_nxt;
   logic [CIDT_PAW-1:0] pa_nxt;
   logic [1:0] tm_nxt, cyc_nxt;

   // Decode the accepted word by its class
   always_comb begin
      dv_nxt = 1'b0;
      cls_nxt = o_class;
      opc_nxt = o_opcode;
      base_nxt = o_base_source_reg;
      src_nxt = o_second_source_reg;
      smod_nxt = o_src_mod;
      dst_nxt = o_destination_reg;
      dmod_nxt = o_dst_mod;
      dval_nxt = o_dst_valid;
      f_nxt = o_file_addr;
      tof_nxt = o_to_file;
      bit_nxt = o_bit_pos;
      bind_nxt = o_bit_indirect;
      lit_nxt = o_literal;
      pa_nxt = o_prog_addr;
      tm_nxt = o_tbl_mode;
      tw_nxt = o_two_word;
      w2_nxt = 1'b0;
      cyc_nxt = o_cycles;
      nop_nxt = (state_r == CIDT_ST_WAIT);
      if (take && state_r == CIDT_ST_WORD2) begin
         // Second word completes the 48-bit instruction
         dv_nxt = 1'b1;
         w2_nxt = 1'b1;
         pa_nxt = {i_instr[6:0], addr_hi_r[15:0]};
      end else if (take) begin
         dv_nxt = 1'b1;
         opc_nxt = op;
         cls_nxt = op_class(op);
         tw_nxt = tw;
         cyc_nxt = cyc;
         dval_nxt = 1'b0;
         bind_nxt = 1'b0;
         tof_nxt = 1'b0;
         nop_nxt = (op == CIDT_OP_NOP);
         unique case (op_class(op))
            CIDT_CLS_DEFAULT_WORKING_REG: begin
               base_nxt = i_instr[CIDT_BASE_LSB +: 4];
               src_nxt = i_instr[CIDT_SRC_LSB +: 4];
               smod_nxt = i_instr[CIDT_SMOD_LSB +: 3];
               dst_nxt = i_instr[CIDT_DEST_LSB +: 4];
               dmod_nxt = i_instr[CIDT_DMOD_LSB +: 3];
               dval_nxt = 1'b1;
            end
            CIDT_CLS_FILE: begin
               f_nxt = i_instr[CIDT_FW-1:0];
               tof_nxt = i_instr[CIDT_FSEL_BIT];
               dst_nxt = 4'h0;
               dval_nxt = !i_instr[CIDT_FSEL_BIT];
            end
            CIDT_CLS_BIT: begin
               src_nxt = i_instr[CIDT_SRC_LSB +: 4];
               smod_nxt = i_instr[CIDT_SMOD_LSB +: 3];
               f_nxt = i_instr[CIDT_FW-1:0];
               tof_nxt = skip_op;
               bind_nxt = i_instr[CIDT_BITIND_BIT];
               base_nxt = i_instr[CIDT_BASE_LSB +: 4];
               bit_nxt = i_instr[CIDT_BIT_LSB +: 4];
            end
            CIDT_CLS_LITMOV: begin
               lit_nxt = i_instr[CIDT_LIT_LSB +: CIDT_LITW];
               base_nxt = i_instr[3:0];
               f_nxt = i_instr[CIDT_FW-1:0];
            end
            CIDT_CLS_LITALU: begin
               base_nxt = i_instr[CIDT_BASE_LSB +: 4];
               lit_nxt = {11'h000, i_instr[CIDT_ALULIT_LSB +: 5]};
               dst_nxt = i_instr[CIDT_DEST_LSB +: 4];
               dmod_nxt = i_instr[CIDT_DMOD_LSB +: 3];
               dval_nxt = (i_instr[CIDT_DEST_LSB +: 4] != i_instr[CIDT_BASE_LSB +: 4]);
            end
            default: begin
               pa_nxt = {{(CIDT_PAW-16){1'b0}}, i_instr[15:0]};
               tm_nxt = i_instr[CIDT_TBLMODE_LSB +: 2];
            end
         endcase
      end
   end

   // Output registers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dec_valid <= 1'b0;
         o_class <= CIDT_CLS_CTRL;
         o_opcode <= 8'h00;
         o_base_source_reg <= 4'h0;
         o_second_source_reg <= 4'h0;
         o_src_mod <= 3'h0;
         o_destination_reg <= 4'h0;
         o_dst_mod <= 3'h0;
         o_dst_valid <= 1'b0;
         o_file_addr <= '0;
         o_to_file <= 1'b0;
         o_bit_pos <= 4'h0;
         o_bit_indirect <= 1'b0;
         o_literal <= '0;
         o_prog_addr <= '0;
         o_tbl_mode <= 2'h0;
         o_two_word <= 1'b0;
         o_second_word <= 1'b0;
         o_cycles <= CIDT_CYC1;
         o_nop_cycle <= 1'b0;
      end else begin
         o_dec_valid <= dv_nxt;
         o_class <= cls_nxt;
         o_opcode <= opc_nxt;
         o_base_source_reg <= base_nxt;
         o_second_source_reg <= src_nxt;
         o_src_mod <= smod_nxt;
         o_destination_reg <= dst_nxt;
         o_dst_mod <= dmod_nxt;
         o_dst_valid <= dval_nxt;
         o_file_addr <= f_nxt;
         o_to_file <= tof_nxt;
         o_bit_pos <= bit_nxt;
         o_bit_indirect <= bind_nxt;
         o_literal <= lit_nxt;
         o_prog_addr <= pa_nxt;
         o_tbl_mode <= tm_nxt;
         o_two_word <= tw_nxt;
         o_second_word <= w2_nxt;
         o_cycles <= cyc_nxt;
         o_nop_cycle <= nop_nxt;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_take_two_word;
      take && tw && state_r == CIDT_ST_IDLE;
   endsequence

   a_two_word_wait: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_take_two_word |=> state_r == CIDT_ST_WORD2)
      else $error("two-word instruction did not wait for its second word");

   a_ret_three_cyc: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_IDLE && op == CIDT_OP_INT_RET) |=> !o_ready [*2] ##1 o_ready)
      else $error("return did not hold three cycles");

   a_dbl_move_two: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_IDLE && op == CIDT_OP_DBL_MOVE) |=> !o_ready ##1 o_ready)
      else $error("double-word move did not take two cycles");

   a_single_one_cyc: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_IDLE && cyc == CIDT_CYC1 && !tw) |=> o_ready && o_dec_valid)
      else $error("single-cycle instruction stalled");

   a_skip_cycles: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_IDLE && skip_op && i_cond_true)
      |=> o_cycles == (($past(i_next_two_word)) ? CIDT_CYC3 : CIDT_CYC2))
      else $error("skip cycle count wrong");

   a_wait_nop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_r == CIDT_ST_WAIT |=> o_nop_cycle && !o_dec_valid)
      else $error("added cycle not reported as no-operation");

   a_file_dest: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_IDLE && op_class(op) == CIDT_CLS_FILE)
      |=> o_to_file == $past(i_instr[CIDT_FSEL_BIT]) && o_dst_valid != o_to_file)
      else $error("file destination select wrong");

   a_lit_dest: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (o_dec_valid && !o_second_word && o_class == CIDT_CLS_LITALU)
      |-> o_dst_valid == (o_destination_reg != o_base_source_reg))
      else $error("literal destination flag wrong");

   a_word2_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (take && state_r == CIDT_ST_WORD2) |=> o_second_word && o_prog_addr[15:0] == $past(addr_hi_r[15:0]))
      else $error("second word not joined");
endmodule

// file: tb/cidt_fetch_model.sv
// Purpose: Fetch-side model that offers program words to the decoder
// Assumes: Items are queued by the bench; a word is taken on a rising edge with ready high
// Notes: Stalls at random; an idle bus toggles each cycle between the last word and its inverse
`timescale 1ns/1ps
module cidt_fetch_model (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ready,
   input wire logic i_push,
   input wire logic [25:0] i_item,
   output logic o_valid,
   output logic [23:0] o_instr,
   output logic o_cond,
   output logic o_next_two,
   output logic o_idle
);
   logic [25:0] q[$];
   logic taken_r;

   // ----------------------------------------
   // Queue and handshake
   // ----------------------------------------
   // Start quiet so the decoder sees no word at time zero
   initial begin
      o_valid = 1'b0;
      o_instr = 24'h000000;
      o_cond = 1'b0;
      o_next_two = 1'b0;
      o_idle = 1'b1;
      taken_r = 1'b0;
   end

   // Accept queued items and note a taken word on the sampling edge
   always @(posedge i_mclk) begin
      if (i_push) begin
         q.push_back(i_item);
      end
      taken_r <= i_rst_n && o_valid && i_ready;
   end

   // Drive off the sampling edge; a refused word is held, a taken one is replaced or dropped once
   always @(negedge i_mclk) begin
      if (taken_r) begin
         void'(q.pop_front());
      end
      if (!i_rst_n) begin
         o_valid = 1'b0;
      end else if (!o_valid || taken_r) begin
         if (q.size() > 0 && $urandom_range(3) != 0) begin
            {o_next_two, o_cond, o_instr} = q[0];
            o_valid = 1'b1;
         end else begin
            o_valid = 1'b0;
            o_instr = ~o_instr; // Stale word must not look valid
            o_cond = ~o_cond;
            o_next_two = ~o_next_two;
         end
      end
      o_idle = (q.size() == 0) && !o_valid;
   end
endmodule

// file: tb/tb_cpu_instruction_decode_timing.sv
// Purpose: Self-checking bench for the instruction decode and timing block
// Assumes: Decoder answers one cycle after a taken word
// Notes: A queue model predicts class, cycles, pairing and ready gaps
`timescale 1ns/1ps
module tb_cpu_instruction_decode_timing;
   import cidt_pkg::*;
   typedef struct {int op; int cyc; bit sec; int pa; logic [23:0] w;} cidt_exp_s;
   logic i_mclk, i_rst_n, i_valid, i_cond_true, i_next_two_word, push, idle;
   logic [23:0] i_instr;
   logic [25:0] item;
   logic o_ready, o_dec_valid, o_two_word, o_second_word, o_nop_cycle;
   cidt_pkg::cidt_class_e o_class;
   logic [7:0] o_opcode;
   logic [22:0] o_prog_addr;
   logic [1:0] o_cycles;
   logic [3:0] o_base_source_reg, o_second_source_reg, o_destination_reg, o_bit_pos;
   logic [2:0] o_src_mod, o_dst_mod;
   logic [1:0] o_tbl_mode;
   logic o_dst_valid, o_to_file, o_bit_indirect;
   logic [12:0] o_file_addr;
   logic [15:0] o_literal;
   cidt_exp_s q[$];
   cidt_exp_s e;
   int err_total = 0;
   int n_checks = 0;
   int wait_cnt = 0;
   int lo16 = 0;
   bit want2 = 1'b0;
   bit nop_due = 1'b0;
   int dir[22] = '{8'h02, 8'h04, 8'h08, 8'h37, 8'h01, 8'h0C, 8'h0D, 8'h06, 8'h07, 8'hBE, 8'hBA,
      8'hBB, 8'h30, 8'h36, 8'hA6, 8'hA7, 8'h00, 8'h20, 8'h40, 8'hA0, 8'hB0, 8'hB4};

   cidt_decoder cidt_decoder_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_instr(i_instr),
      .i_cond_true(i_cond_true), .i_next_two_word(i_next_two_word), .o_ready(o_ready), .o_dec_valid(o_dec_valid),
      .o_class(o_class), .o_opcode(o_opcode), .o_base_source_reg(o_base_source_reg),
      .o_second_source_reg(o_second_source_reg), .o_src_mod(o_src_mod), .o_destination_reg(o_destination_reg),
      .o_dst_mod(o_dst_mod), .o_dst_valid(o_dst_valid), .o_file_addr(o_file_addr), .o_to_file(o_to_file),
      .o_bit_pos(o_bit_pos), .o_bit_indirect(o_bit_indirect), .o_literal(o_literal), .o_prog_addr(o_prog_addr),
      .o_tbl_mode(o_tbl_mode), .o_two_word(o_two_word),
      .o_second_word(o_second_word), .o_cycles(o_cycles), .o_nop_cycle(o_nop_cycle));

   cidt_fetch_model cidt_fetch_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ready(o_ready), .i_push(push),
      .i_item(item), .o_valid(i_valid), .o_instr(i_instr), .o_cond(i_cond_true), .o_next_two(i_next_two_word),
      .o_idle(idle));

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   // Cycle count of a word given its condition and the word after it
   function automatic int f_cyc(input int op, input bit c, input bit nt);
      if (op inside {8'h06, 8'h07}) return 3;
      if (op inside {8'h02, 8'h04, 8'h08, 8'hBE, 8'h37, 8'h01, 8'h0C, 8'h0D, 8'hBA, 8'hBB}) return 2;
      if (op inside {[8'h30:8'h36]}) return c ? 2 : 1;
      if (op inside {8'hA6, 8'hA7}) return c ? (nt ? 3 : 2) : 1;
      return 1;
   endfunction

   // Operand class from the opcode ranges
   function automatic int f_cls(input int op);
      if (op inside {[8'h20:8'h2F]}) return 4;
      if (op inside {[8'h40:8'h77]}) return 1;
      if (op inside {[8'hA0:8'hAF]}) return 3;
      if (op inside {[8'hB0:8'hB3]}) return 5;
      if (op inside {[8'hB4:8'hB9]}) return 2;
      return 0;
   endfunction

   // Predict each taken word and the following gap in ready
   always @(posedge i_mclk) begin
      nop_due = i_rst_n && wait_cnt > 0;
      if (!i_rst_n) begin
         wait_cnt = 0;
         want2 = 1'b0;
      end else if (i_valid && o_ready) begin
         if (want2) begin
            q.push_back('{0, 0, 1'b1, {i_instr[6:0], lo16[15:0]}, i_instr});
            want2 = 1'b0;
            wait_cnt = 0;
         end else begin
            q.push_back('{int'(i_instr[23:16]), f_cyc(i_instr[23:16], i_cond_true, i_next_two_word), 1'b0, 0,
               i_instr});
            want2 = i_instr[23:16] inside {8'h02, 8'h04, 8'h08};
            lo16 = i_instr[15:0];
            wait_cnt = want2 ? 0 : q[$].cyc - 1;
         end
      end else if (wait_cnt > 0) begin
         wait_cnt--;
      end
   end

   // ----------------------------------------
   // Compare and report
   // ----------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Check settled outputs mid-cycle against the model
   always @(negedge i_mclk) begin
      if (i_rst_n) begin
         chk_bit(o_ready, wait_cnt == 0, "ready");
         if (o_dec_valid === 1'b1 && q.size() == 0) begin
            chk_bit(1'b1, 1'b0, "extra result");
         end else if (o_dec_valid === 1'b1) begin
            e = q.pop_front();
            chk_bit(o_second_word, e.sec, "second word flag");
            if (e.sec) begin
               chk_val({9'h000, o_prog_addr}, e.pa, "paired address");
            end else begin
               chk_val({24'h000000, o_opcode}, e.op, "opcode");
               chk_val({29'h0, o_class}, f_cls(e.op), "class");
               chk_val({30'h0, o_cycles}, e.cyc, "cycles");
               chk_bit(o_two_word, e.op inside {8'h02, 8'h04, 8'h08}, "two word");
               chk_bit(o_nop_cycle, e.op == 0, "zero opcode nop");
               case (f_cls(e.op))
                  1: begin
                     chk_val(32'(o_base_source_reg), 32'(e.w[CIDT_BASE_LSB +: 4]), "base");
                     chk_val(32'(o_second_source_reg), 32'(e.w[CIDT_SRC_LSB +: 4]), "src");
                     chk_val(32'(o_src_mod), 32'(e.w[CIDT_SMOD_LSB +: 3]), "smod");
                     chk_val(32'(o_destination_reg), 32'(e.w[CIDT_DEST_LSB +: 4]), "dst");
                     chk_val(32'(o_dst_mod), 32'(e.w[CIDT_DMOD_LSB +: 3]), "dmod");
                     chk_bit(o_dst_valid, 1'b1, "dst written");
                  end
                  2: begin
                     chk_val(32'(o_file_addr), 32'(e.w[CIDT_FW-1:0]), "file addr");
                     chk_bit(o_to_file, e.w[CIDT_FSEL_BIT], "to file");
                     chk_bit(o_dst_valid, !e.w[CIDT_FSEL_BIT], "to reg zero");
                     chk_val(32'(o_destination_reg), 0, "reg zero");
                  end
                  3: begin
                     chk_val(32'(o_bit_pos), 32'(e.w[CIDT_BIT_LSB +: 4]), "bit pos");
                     chk_bit(o_bit_indirect, e.w[CIDT_BITIND_BIT], "bit indirect");
                     chk_val(32'(o_file_addr), 32'(e.w[CIDT_FW-1:0]), "bit file");
                  end
                  4: begin
                     chk_val(32'(o_literal), 32'(e.w[CIDT_LIT_LSB +: CIDT_LITW]), "move lit");
                     chk_val(32'(o_base_source_reg), 32'(e.w[3:0]), "move reg");
                  end
                  5: begin
                     chk_val(32'(o_base_source_reg), 32'(e.w[CIDT_BASE_LSB +: 4]), "alu base");
                     chk_val(32'(o_literal), 32'(e.w[CIDT_ALULIT_LSB +: 5]), "alu lit");
                     chk_bit(o_dst_valid, e.w[CIDT_DEST_LSB +: 4] != e.w[CIDT_BASE_LSB +: 4], "alu dst");
                  end
                  default: begin
                     chk_val(32'(o_prog_addr), 32'(e.w[15:0]), "prog addr");
                     chk_val(32'(o_tbl_mode), 32'(e.w[CIDT_TBLMODE_LSB +: 2]), "tbl mode");
                  end
               endcase
            end
         end else begin
            chk_bit(o_dec_valid, 1'b0, "valid pulse");
            chk_bit(o_nop_cycle, nop_due, "wait nop");
         end
      end
   end

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   // Queue one word for the fetch model
   task automatic put(input logic [23:0] w, input logic c, input logic nt);
      item = {nt, c, w};
      push = 1'b1;
      @(negedge i_mclk);
   endtask

   // Queue an instruction; two-word ones get a second word with a zero top byte
   task automatic add(input int op, input bit c, input bit nt);
      put({op[7:0], 16'($urandom)}, c, nt);
      if (op inside {8'h02, 8'h04, 8'h08}) begin
         put({8'h00, 16'($urandom)}, 1'($urandom), 1'($urandom));
      end
   endtask

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // Reset, directed opcode table, then random words
   initial begin
      i_rst_n = 1'b0;
      push = 1'b0;
      item = 26'h0000000;
      void'($urandom(32'h7F6F59F6));
      repeat (5) @(negedge i_mclk);
      i_rst_n = 1'b1;
      foreach (dir[k]) for (int m = 0; m < 4; m++) add(dir[k], m[0], m[1]);
      repeat (200) add($urandom_range(255), 1'($urandom), 1'($urandom));
      push = 1'b0;
      for (int t = 0; t < 5000 && !(idle && wait_cnt == 0 && q.size() == 0); t++) @(negedge i_mclk);
      repeat (2) @(negedge i_mclk);
      chk_val(q.size(), 0, "missing results");
      chk_bit(idle, 1'b1, "fetch not drained");
      give_verdict();
   end

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_total++;
      give_verdict();
   end
endmodule
